// >>> common/frq_pkg.sv
// Package with constants for the frequency relay output and indication block
// Behaviour
// - Matrix switches route any stage start or trip to any start or trip output.
// - Continuous outputs follow their controlling stage for as long as it is active.
// - Pulsed outputs assert for the programmed pulse length only, then drop.
// - Selected outputs light the shared trip lamp, which stays lit afterwards.
// - Bank-select subregister 0 selects main bank, 1 selects second bank.
// - Serial bank command or assigned control input also switches the bank.
// - While a control input selects the bank, serial and key requests are ignored.
// - Bank indicator flashes whenever the second bank is active.
// - Serial bus reaches both banks; front keys reach only the active bank.
// - Reset key or dark program clears indicators; both keys or serial clears all.
// - Control input clears indicators or everything, chosen by two switches.
// - Trip code and trip lamp stay latched until reset, even after stage resets.
// - Start code goes out when stage resets unless latch switch is set.
// - A started stage that trips shows its trip code instead of its start code.
// - Codes 1 to 8 are start and trip per stage; 9 recovery running, 10 operated.
// - Permanent internal fault lights the alarm lamp and drives the alarm contact.
// - Internal fault diagnostic code is cleared only by presetn, never by key, serial or input resets.
// - Rated frequency defaults to 50 Hz, measurement cycle count to 6.
// - Undervoltage threshold 0.30 to 0.90 of rated voltage, default 0.60.
// - Per stage threshold and timer; defaults 51, 49, 48, 47 Hz, 0.15 s.
// - One rate-of-change threshold per bank, default 1.0 Hz/s.
// - Recovery half-width defaults to 0.20 Hz, recovery time to 10 min.
package frq_pkg;
    localparam int          CLK_HZ         = 100_000_000;
    localparam int          TICK_US        = 10;
    localparam int          TICK_CYC       = CLK_HZ / 1_000_000 * TICK_US;
    localparam int          FLASH_TICKS    = 25_000;
    localparam logic [11:0] ADDR_CFG       = 12'h000;
    localparam logic [11:0] ADDR_MATRIX    = 12'h004;
    localparam logic [11:0] ADDR_MODE      = 12'h008;
    localparam logic [11:0] ADDR_CTRL      = 12'h00c;
    localparam logic [11:0] ADDR_STATUS    = 12'h010;
    localparam logic [11:0] ADDR_PULSE     = 12'h014;
    localparam logic [11:0] ADDR_FAULT     = 12'h018;
    localparam logic [11:0] ADDR_SET_BASE  = 12'h100;
    localparam int          SET_WORDS      = 16;
    localparam int          CTRL_BANK_CMD  = 0;
    localparam int          CTRL_RESET_ALL = 1;
    localparam int          CFG_EXT_BANK   = 0;
    localparam int          CFG_EXT_IND    = 1;
    localparam int          CFG_EXT_ALL    = 2;
    localparam int          CFG_LATCH_ST   = 3;
    localparam logic [31:0] CFG_RST        = 32'h0000_0000;
    localparam logic [31:0] MATRIX_RST     = 32'h8421_8421;
    localparam logic [31:0] MODE_RST       = 32'h0000_0aff;
    localparam logic [15:0] PULSE_RST      = 16'h2710;
    localparam logic [3:0]  CODE_REC_RUN   = 4'h9;
    localparam logic [3:0]  CODE_REC_DONE  = 4'ha;
    localparam logic [15:0] FN_RST         = 16'h1388;
    localparam logic [15:0] NCYC_RST       = 16'h0006;
    localparam logic [15:0] UV_RST         = 16'h003c;
    localparam logic [15:0] F1_RST         = 16'h13ec;
    localparam logic [15:0] F2_RST         = 16'h1324;
    localparam logic [15:0] F3_RST         = 16'h12c0;
    localparam logic [15:0] F4_RST         = 16'h125c;
    localparam logic [15:0] T2_RST         = 16'h000f;
    localparam logic [15:0] DFDT_RST       = 16'h000a;
    localparam logic [15:0] FR_RST         = 16'h0014;
    localparam logic [15:0] TR_RST         = 16'h0258;
endpackage : frq_pkg

// >>> verilog/frq_relay.sv
// Output matrix, indication, setting bank and reset logic of the frequency relay
`timescale 1ns/1ps
module frq_relay (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic [3:0]  stage_start,
    input  wire logic [3:0]  stage_trip,
    input  wire logic        rec_running,
    input  wire logic        rec_operated,
    input  wire logic [4:0]  external_control_inputs,
    input  wire logic [2:0]  ext_bank_sel_idx,
    input  wire logic [2:0]  ext_reset_idx,
    input  wire logic        key_reset,
    input  wire logic        key_program,
    input  wire logic        display_dark,
    input  wire logic        key_bank_wr,
    input  wire logic        key_bank_val,
    input  wire logic        key_set_wr,
    input  wire logic [3:0]  key_set_idx,
    input  wire logic [15:0] key_set_data,
    output logic      [15:0] key_set_rdata,
    input  wire logic        fault_detect,
    input  wire logic [3:0]  fault_diag,
    output logic      [3:0]  start_outputs,
    output logic      [3:0]  trip_outputs,
    output logic             trip_lamp,
    output logic             bank_active,
    output logic             bank_lamp,
    output logic      [3:0]  operation_code_parameter,
    output logic             self_supervision_alarm,
    output logic             alarm_contact,
    output logic      [3:0]  fault_code,
    output logic             reg_clear
);
    import frq_pkg::*;

    logic [31:0] cfg, matrix, mode;
    logic [15:0] pulse_len;
    logic [15:0] bank_mem [2][SET_WORDS];
    logic        bank_sel;
    logic [15:0] tick_cnt;
    logic        tick;
    logic [15:0] flash_cnt;
    logic        flash;
    logic [7:0]  sig_now, sig_prev, sig_out, lamp_en;
    logic [15:0] pcnt [8];
    logic [3:0]  st_lat, tr_lat;
    logic        fault_lat;
    logic [3:0]  fault_hold;

    wire         wr_en    = psel && penable && pwrite;
    wire         sel_cfg  = paddr == ADDR_CFG;
    wire         sel_mat  = paddr == ADDR_MATRIX;
    wire         sel_mode = paddr == ADDR_MODE;
    wire         sel_ctrl = paddr == ADDR_CTRL;
    wire         sel_stat = paddr == ADDR_STATUS;
    wire         sel_pul  = paddr == ADDR_PULSE;
    wire         sel_flt  = paddr == ADDR_FAULT;
    wire         sel_set  = paddr[11:8] == ADDR_SET_BASE[11:8] && paddr[7] == 1'b0;
    wire         set_bank = paddr[6];
    wire  [3:0]  set_idx  = paddr[5:2];
    wire         mapped   = sel_cfg | sel_mat | sel_mode | sel_ctrl | sel_stat
                          | sel_pul | sel_flt | sel_set;
    wire         ext_bank_on  = cfg[CFG_EXT_BANK];
    wire         ext_bank_lvl = external_control_inputs[ext_bank_sel_idx];
    wire         ext_rst_lvl  = external_control_inputs[ext_reset_idx];
    wire         ser_bank_wr  = wr_en && sel_ctrl;
    wire         ser_rst_all  = ser_bank_wr && pwdata[CTRL_RESET_ALL];
    wire         clr_all  = (key_reset && key_program) || ser_rst_all
                          || (ext_rst_lvl && cfg[CFG_EXT_ALL]);
    wire         clr_ind  = clr_all || (key_reset && !key_program)
                          || (key_program && !key_reset && display_dark)
                          || (ext_rst_lvl && cfg[CFG_EXT_IND]);
    wire         next_bank = ext_bank_on ? ext_bank_lvl :
                             key_bank_wr ? key_bank_val :
                             ser_bank_wr ? pwdata[CTRL_BANK_CMD] : bank_sel;

    assign pready  = 1'b1;
    assign pslverr = psel && penable && !mapped;

    // Time base tick
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tick_cnt <= '0;
        end else begin
            tick_cnt <= tick ? '0 : tick_cnt + 16'h0001;
        end
    end
    assign tick = tick_cnt == 16'(TICK_CYC - 1);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg       <= CFG_RST;
            matrix    <= MATRIX_RST;
            mode      <= MODE_RST;
            pulse_len <= PULSE_RST;
            bank_sel  <= 1'b0;
        end else begin
            if (wr_en && sel_cfg) cfg <= pwdata;
            if (wr_en && sel_mat) matrix <= pwdata;
            if (wr_en && sel_mode) mode <= pwdata;
            if (wr_en && sel_pul) pulse_len <= pwdata[15:0];
            bank_sel <= next_bank;
        end
    end
    assign bank_active = bank_sel;

    // Settings banks; serial reaches both, keys only the active one
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int b = 0; b < 2; b++) begin
                bank_mem[b][0]  <= FN_RST;
                bank_mem[b][1]  <= NCYC_RST;
                bank_mem[b][2]  <= UV_RST;
                bank_mem[b][3]  <= F1_RST;
                bank_mem[b][4]  <= F2_RST;
                bank_mem[b][5]  <= F3_RST;
                bank_mem[b][6]  <= F4_RST;
                for (int s = 0; s < 4; s++) begin
                    bank_mem[b][7+s] <= T2_RST;
                end
                bank_mem[b][11] <= DFDT_RST;
                bank_mem[b][12] <= FR_RST;
                bank_mem[b][13] <= TR_RST;
                bank_mem[b][14] <= '0;
                bank_mem[b][15] <= '0;
            end
        end else begin
            if (wr_en && sel_set) begin
                bank_mem[set_bank][set_idx] <= pwdata[15:0];
            end else if (key_set_wr) begin
                bank_mem[bank_sel][key_set_idx] <= key_set_data;
            end
        end
    end
    assign key_set_rdata = bank_mem[bank_sel][key_set_idx];

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flash_cnt <= '0;
            flash     <= 1'b0;
        end else if (tick) begin
            flash_cnt <= (flash_cnt == 16'(FLASH_TICKS - 1)) ? '0 : flash_cnt + 16'h0001;
            if (flash_cnt == 16'(FLASH_TICKS - 1)) flash <= !flash;
        end
    end
    assign bank_lamp = bank_sel && flash;

    // Output matrix and pulse limit per output; outputs 0..3 start, 4..7 trip
    genvar g;
    generate
        for (g = 0; g < 8; g++) begin : g_out
            wire [3:0] route = matrix[g*4 +: 4];
            assign sig_now[g] = |(route & (mode[8+g] ? stage_trip : stage_start));
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    pcnt[g] <= '0;
                end else if (sig_now[g] && !sig_prev[g]) begin
                    pcnt[g] <= pulse_len;
                end else if (tick && pcnt[g] != 16'h0000) begin
                    pcnt[g] <= pcnt[g] - 16'h0001;
                end
            end
            assign sig_out[g] = mode[g] ? sig_now[g]
                              : sig_now[g] && (pcnt[g] != 16'h0000 || !sig_prev[g]);
            assign lamp_en[g] = cfg[8+g];
        end
    endgenerate

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sig_prev      <= '0;
            start_outputs <= '0;
            trip_outputs  <= '0;
            trip_lamp     <= 1'b0;
            st_lat        <= '0;
            tr_lat        <= '0;
        end else begin
            sig_prev      <= sig_now;
            start_outputs <= sig_out[3:0];
            trip_outputs  <= sig_out[7:4];
            trip_lamp     <= |(sig_out & lamp_en) || (trip_lamp && !clr_ind);
            tr_lat        <= stage_trip | (tr_lat & {4{!clr_ind}});
            st_lat        <= stage_start | (st_lat & {4{cfg[CFG_LATCH_ST] && !clr_ind}});
        end
    end

    // Display code: lowest latched stage wins; its trip wins over its start
    logic [3:0] next_code;
    always_comb begin
        next_code = 4'h0;
        if (rec_operated) next_code = CODE_REC_DONE;
        else if (rec_running) next_code = CODE_REC_RUN;
        for (int s = 3; s >= 0; s--) begin
            if (tr_lat[s]) next_code = 4'(2*s + 2);
            else if (st_lat[s]) next_code = 4'(2*s + 1);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            operation_code_parameter <= '0;
            fault_lat                <= 1'b0;
            fault_hold               <= '0;
            reg_clear                <= 1'b0;
        end else begin
            operation_code_parameter <= next_code;
            reg_clear                <= clr_all;
            if (fault_detect && !fault_lat) fault_hold <= fault_diag;
            fault_lat <= fault_lat || fault_detect;
        end
    end
    assign self_supervision_alarm = fault_lat;
    assign alarm_contact          = fault_lat;
    assign fault_code             = fault_hold;

    logic [31:0] rd_mux;
    always_comb begin
        rd_mux = 32'h0000_0000;
        if (sel_cfg) rd_mux = cfg;
        if (sel_mat) rd_mux = matrix;
        if (sel_mode) rd_mux = mode;
        if (sel_ctrl) rd_mux = {31'h0, bank_sel};
        if (sel_stat) rd_mux = {8'h0, fault_hold, operation_code_parameter, tr_lat, st_lat,
                                trip_outputs, start_outputs};
        if (sel_pul) rd_mux = {16'h0, pulse_len};
        if (sel_flt) rd_mux = {27'h0, fault_lat, fault_hold};
        if (sel_set) rd_mux = {16'h0, bank_mem[set_bank][set_idx]};
    end
    assign prdata = rd_mux;

    matrix_route_a: assert property (@(posedge pclk) disable iff (!presetn)
        mode[0] && mode[8] == 1'b0 ##1 $stable(mode) |-> start_outputs[0] == $past(sig_now[0]))
        else $error("continuous output wrong");
    trip_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
        tr_lat[0] && !clr_ind |=> tr_lat[0]) else $error("trip latch lost");
    fault_keep_a: assert property (@(posedge pclk) disable iff (!presetn)
        fault_lat |=> fault_lat && $stable(fault_hold)) else $error("fault cleared");
    bank_ext_a: assert property (@(posedge pclk) disable iff (!presetn)
        ext_bank_on |=> bank_sel == $past(ext_bank_lvl)) else $error("bank not from input");
    lamp_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
        trip_lamp && !clr_ind |=> trip_lamp) else $error("lamp dropped");
    bank_flash_a: assert property (@(posedge pclk) disable iff (!presetn)
        !bank_sel |-> !bank_lamp) else $error("lamp flashes on main bank");
    code_trip_a: assert property (@(posedge pclk) disable iff (!presetn)
        tr_lat[0] |=> operation_code_parameter == 4'h2) else $error("trip code missing");
    clear_all_a: assert property (@(posedge pclk) disable iff (!presetn)
        key_reset && key_program |=> reg_clear) else $error("register clear missing");
    pulse_stop_a: assert property (@(posedge pclk) disable iff (!presetn)
        !mode[0] && sig_prev[0] && pcnt[0] == 16'h0000 |=> !start_outputs[0])
        else $error("pulse too long");
    pulse_end_c: cover property (@(posedge pclk) disable iff (!presetn)
        !mode[0] && start_outputs[0] ##1 !start_outputs[0] && sig_prev[0]);
    bank_two_c: cover property (@(posedge pclk) disable iff (!presetn) bank_sel && bank_lamp);
    rec_code_c: cover property (@(posedge pclk) disable iff (!presetn)
        operation_code_parameter == CODE_REC_DONE);
endmodule : frq_relay

// >>> bench/frq_host.sv
// APB host model issuing register transfers to the relay block
`timescale 1ns/1ps
module frq_host (
    input  wire logic        pclk,
    input  wire logic        pready,
    input  wire logic        pslverr,
    input  wire logic [31:0] prdata,
    output logic             psel,
    output logic             penable,
    output logic             pwrite,
    output logic      [11:0] paddr,
    output logic      [31:0] pwdata
);
    initial begin
        {psel, penable, pwrite, paddr, pwdata} = '0;
    end
    // Setup, then access held until pready; also carries bank commands
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                        output logic [31:0] rd, output logic err);
        @(posedge pclk);
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : xfer
endmodule : frq_host

// >>> bench/frq_relay_tb.sv
// Self-checking testbench of the relay output and indication block
`timescale 1ns/1ps
module frq_relay_tb;
    import frq_pkg::*;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [3:0]  stage_start, stage_trip, key_set_idx, fault_diag, start_outputs, trip_outputs;
    logic [3:0]  operation_code_parameter, fault_code, nib;
    logic [4:0]  external_control_inputs;
    logic [2:0]  ext_bank_sel_idx, ext_reset_idx;
    logic [15:0] key_set_data, key_set_rdata;
    logic        rec_running, rec_operated, key_reset, key_program, display_dark, key_bank_wr;
    logic        key_bank_val, key_set_wr, fault_detect, trip_lamp, bank_active, bank_lamp;
    logic        self_supervision_alarm, alarm_contact, reg_clear;
    int          failures = 0, n_checks = 0, n_clr = 0, cyc = 0, c0;
    logic [11:0] def_a [13] = '{ADDR_CFG, ADDR_MATRIX, ADDR_MODE, ADDR_PULSE, 12'h100, 12'h104,
        12'h108, 12'h10c, 12'h118, 12'h11c, 12'h12c, 12'h130, 12'h174};
    logic [31:0] def_v [13] = '{CFG_RST, MATRIX_RST, MODE_RST, 32'(PULSE_RST), 32'(FN_RST),
        32'(NCYC_RST), 32'(UV_RST), 32'(F1_RST), 32'(F4_RST), 32'(T2_RST), 32'(DFDT_RST),
        32'(FR_RST), 32'(TR_RST)};

    frq_host u_host (.pclk(pclk), .pready(pready), .pslverr(pslverr), .prdata(prdata),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata));
    frq_relay u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .stage_start(stage_start), .stage_trip(stage_trip),
        .rec_running(rec_running), .rec_operated(rec_operated),
        .external_control_inputs(external_control_inputs), .ext_bank_sel_idx(ext_bank_sel_idx),
        .ext_reset_idx(ext_reset_idx), .key_reset(key_reset), .key_program(key_program),
        .display_dark(display_dark), .key_bank_wr(key_bank_wr), .key_bank_val(key_bank_val),
        .key_set_wr(key_set_wr), .key_set_idx(key_set_idx), .key_set_data(key_set_data),
        .key_set_rdata(key_set_rdata), .fault_detect(fault_detect), .fault_diag(fault_diag),
        .start_outputs(start_outputs), .trip_outputs(trip_outputs), .trip_lamp(trip_lamp),
        .bank_active(bank_active), .bank_lamp(bank_lamp),
        .operation_code_parameter(operation_code_parameter),
        .self_supervision_alarm(self_supervision_alarm), .alarm_contact(alarm_contact),
        .fault_code(fault_code), .reg_clear(reg_clear));

    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end
    always @(posedge pclk) begin
        if (reg_clear === 1'b1) n_clr <= n_clr + 1;
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            failures++;
            conclude();
        end
    end

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            failures++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask : check
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        u_host.xfer(1'b1, a, d, rd, err);
    endtask : wr
    task automatic rdc(input string what, input logic [11:0] a, input logic [31:0] exp);
        u_host.xfer(1'b0, a, 32'h0, rd, err);
        check(what, exp, rd);
    endtask : rdc
    task automatic tick(input int n);
        repeat (n) @(posedge pclk);
    endtask : tick
    task automatic stage(input logic [3:0] s, input logic [3:0] t);
        @(posedge pclk);
        stage_start <= s;
        stage_trip  <= t;
        tick(3);
    endtask : stage
    task automatic keys(input logic [1:0] k);
        @(posedge pclk);
        {key_reset, key_program} <= k;
        @(posedge pclk);
        {key_reset, key_program} <= 2'b00;
        tick(3);
    endtask : keys
    task automatic kbank(input logic v);
        @(posedge pclk);
        {key_bank_wr, key_bank_val} <= {1'b1, v};
        @(posedge pclk);
        key_bank_wr <= 1'b0;
        tick(3);
    endtask : kbank
    task automatic conclude;
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : conclude

    initial begin
        presetn = 1'b0;
        {stage_start, stage_trip, rec_running, rec_operated, external_control_inputs} = '0;
        {key_reset, key_program, display_dark, key_bank_wr, key_bank_val, key_set_wr} = '0;
        {key_set_idx, key_set_data, fault_detect, fault_diag} = '0;
        ext_bank_sel_idx = 3'h1;
        ext_reset_idx = 3'h3;
        repeat (8) @(posedge pclk);
        check("reset outs", 32'h0, 32'({start_outputs, trip_outputs, trip_lamp, reg_clear}));
        presetn <= 1'b1;
        for (int i = 0; i < 13; i++) begin
            rdc("default", def_a[i], def_v[i]);
        end
        u_host.xfer(1'b0, 12'hffc, 32'h0, rd, err);
        check("unmapped", 32'h1, 32'(err));
        $display("test defaults done");
        wr(ADDR_MODE, 32'h0000_f0ff);
        for (int s = 0; s < 4; s++) begin
            nib = 4'h1 << s;
            wr(ADDR_MATRIX, {8{nib}});
            stage(nib, 4'h0);
            check("start out", 32'hf, 32'({trip_outputs, start_outputs}));
            check("start code", 32'(2 * s + 1), 32'(operation_code_parameter));
            tick(20);
            check("continuous", 32'hf, 32'(start_outputs));
            stage(nib, nib);
            check("trip out", 32'hf, 32'(trip_outputs));
            check("trip code", 32'(2 * s + 2), 32'(operation_code_parameter));
            stage(4'h0, 4'h0);
            check("trip latch", 32'(2 * s + 2), 32'(operation_code_parameter));
            keys(2'b10);
            check("key clear", 32'h0, 32'(operation_code_parameter));
            stage(nib, 4'h0);
            stage(4'h0, 4'h0);
            check("start gone", 32'h0, 32'(operation_code_parameter));
        end
        wr(ADDR_CFG, 32'h1 << CFG_LATCH_ST);
        stage(4'h2, 4'h0);
        stage(4'h0, 4'h0);
        check("start kept", 32'h3, 32'(operation_code_parameter));
        display_dark <= 1'b1;
        c0 = n_clr;
        keys(2'b01);
        check("dark clear", 32'h0, 32'(operation_code_parameter));
        check("no reg clr", 32'(c0), 32'(n_clr));
        rec_running <= 1'b1;
        tick(3);
        check("rec run", 32'(CODE_REC_RUN), 32'(operation_code_parameter));
        {rec_running, rec_operated} <= 2'b01;
        tick(3);
        check("rec done", 32'(CODE_REC_DONE), 32'(operation_code_parameter));
        rec_operated <= 1'b0;
        keys(2'b10);
        $display("test codes done");
        wr(ADDR_PULSE, 32'h3);
        wr(ADDR_MODE, 32'h0000_f000);
        wr(ADDR_MATRIX, 32'h1111_1111);
        stage(4'h1, 4'h0);
        check("pulse on", 32'hf, 32'(start_outputs));
        tick(4 * TICK_CYC);
        check("pulse off", 32'h0, 32'(start_outputs));
        wr(ADDR_MODE, 32'h0000_f0ff);
        wr(ADDR_CFG, 32'h0000_1000);
        check("lamp unsel", 32'h0, 32'(trip_lamp));
        stage(4'h0, 4'h1);
        check("lamp on", 32'h1, 32'(trip_lamp));
        stage(4'h0, 4'h0);
        check("lamp kept", 32'h1, 32'(trip_lamp));
        keys(2'b10);
        check("lamp clear", 32'h0, 32'(trip_lamp));
        $display("test outputs done");
        c0 = n_clr;
        keys(2'b11);
        check("both keys", 32'(c0 + 1), 32'(n_clr));
        wr(ADDR_CTRL, 32'h1 << CTRL_RESET_ALL);
        tick(3);
        check("serial clr", 32'(c0 + 2), 32'(n_clr));
        for (int m = 0; m < 2; m++) begin
            wr(ADDR_CFG, m ? 32'h1 << CFG_EXT_ALL : 32'h1 << CFG_EXT_IND);
            stage(4'h0, 4'h4);
            stage(4'h0, 4'h0);
            c0 = n_clr;
            @(posedge pclk);
            external_control_inputs <= 5'h08;
            @(posedge pclk);
            external_control_inputs <= 5'h00;
            tick(3);
            check("ext ind", 32'h0, 32'(operation_code_parameter));
            check("ext reg", 32'(c0 + m), 32'(n_clr));
        end
        $display("test resets done");
        wr(ADDR_CFG, 32'h0);
        check("bank lamp", 32'h0, 32'({bank_active, bank_lamp}));
        wr(ADDR_CTRL, 32'h1 << CTRL_BANK_CMD);
        tick(2);
        check("serial bank", 32'h1, 32'(bank_active));
        rdc("ctrl bank", ADDR_CTRL, 32'h1);
        @(posedge pclk);
        {key_set_wr, key_set_idx, key_set_data} <= {1'b1, 4'h3, 16'h1357};
        @(posedge pclk);
        key_set_wr <= 1'b0;
        tick(2);
        check("key rdata", 32'h1357, 32'(key_set_rdata));
        rdc("bank1 set", 12'h14c, 32'h1357);
        rdc("bank0 set", 12'h10c, 32'(F1_RST));
        wr(12'h108, 32'h0000_0042);
        rdc("serial set", 12'h108, 32'h42);
        kbank(1'b0);
        check("key bank", 32'h0, 32'(bank_active));
        check("key act", 32'(F1_RST), 32'(key_set_rdata));
        wr(ADDR_CFG, 32'h1 << CFG_EXT_BANK);
        external_control_inputs <= 5'h02;
        tick(3);
        check("ext bank", 32'h1, 32'(bank_active));
        wr(ADDR_CTRL, 32'h0);
        kbank(1'b0);
        check("bank held", 32'h1, 32'(bank_active));
        external_control_inputs <= 5'h00;
        tick(3);
        check("ext main", 32'h0, 32'(bank_active));
        $display("test bank done");
        {fault_detect, fault_diag} <= {1'b1, 4'h5};
        tick(3);
        check("alarm", 32'h7, 32'({self_supervision_alarm, alarm_contact, 1'b1}));
        fault_diag <= 4'h9;
        keys(2'b11);
        wr(ADDR_CTRL, 32'h1 << CTRL_RESET_ALL);
        tick(3);
        check("fault kept", 32'h5, 32'(fault_code));
        $display("test fault done");
        conclude();
    end
endmodule : frq_relay_tb
